//--- sqs_pkg.sv
// Functional notes
// - Bit 15 selects direction: 1 writes the entry, 0 reads it.
// - Bits 14 to 9 hold the entry's own address, which must match.
// - Return bit 8 at 0 moves the sequencer on after the conversion.
// - Return bit 8 at 1 sends the sequencer back to the first entry.
// - Bits 7 to 4 choose the converter B input channel for the step.
// - Bits 3 to 0 choose the converter A input channel for the step.
// - Entry fourteen resets to 0x5c00, self address 101110b, rest zero.
// - Entry fifteen resets to 0x5e00, self address 101111b, rest zero.
// - Entry thirteen resets to 0x5a00, self address 101101b, rest zero.
//
// Purpose: constants for the sequencer stack slots thirteen to fifteen
// Assumes: 32-bit AHB-Lite word registers
// Notes:   Entry offsets are register indices; byte address is four times
package sqs_pkg;
  localparam int          NUM_SLOTS     = 3;
  localparam logic [7:0]  IDX_SLOT_13   = 8'h2d;
  localparam logic [7:0]  IDX_SLOT_14   = 8'h2e;
  localparam logic [7:0]  IDX_SLOT_15   = 8'h2f;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [15:0] RST_SLOT_13   = 16'h5a00;
  localparam logic [15:0] RST_SLOT_14   = 16'h5c00;
  localparam logic [15:0] RST_SLOT_15   = 16'h5e00;
  localparam logic [5:0]  SELF_13       = 6'h2d;
  localparam logic [5:0]  SELF_14       = 6'h2e;
  localparam logic [5:0]  SELF_15       = 6'h2f;
  localparam int          BIT_DIR       = 15;
  localparam int          SELF_HI       = 14;
  localparam int          SELF_LO       = 9;
  localparam int          BIT_RET       = 8;
  localparam int          CHB_HI        = 7;
  localparam int          CHB_LO        = 4;
  localparam int          CHA_HI        = 3;
  localparam int          CHA_LO        = 0;
  localparam int          CTRL_RUN      = 0;
  localparam int          STAT_SLOT_LO  = 8;
  localparam logic [1:0]  SLOT_FIRST    = 2'h0;
  localparam logic [1:0]  SLOT_LAST     = 2'h2;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
endpackage

//--- sqs_slot.sv
// Purpose: one sequencer stack entry
// Assumes: write strobe already decoded for this entry
// Notes:   Accesses with wrong self address or read direction leave it alone
module sqs_slot #(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [5:0]  SELF    = 6'h00
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Write side
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  // Contents
  output logic      [15:0] value
);
  logic [15:0] value_ff;
  logic        accept;

  assign accept = wr_en && wdata[sqs_pkg::BIT_DIR]
                  && (wdata[sqs_pkg::SELF_HI:sqs_pkg::SELF_LO] == SELF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_ff <= RST_VAL;
    end else if (accept) begin
      value_ff <= wdata;
    end
  end

  assign value = value_ff;
endmodule

//--- sqs_top.sv
// Purpose: AHB-Lite bank of stack entries thirteen to fifteen and stepper
// Assumes: conv_done is a one-cycle pulse at the end of each conversion
// Notes:   Zero wait states; response is always OKAY
//
// Added by the designer: register access over AHB-Lite.
module sqs_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Converter side
  input  wire logic        conv_done,
  output logic      [3:0]  converter_a_channel_select,
  output logic      [3:0]  converter_b_channel_select,
  output logic      [1:0]  active_slot
);
  logic [15:0] slot_val [sqs_pkg::NUM_SLOTS];
  logic [sqs_pkg::NUM_SLOTS-1:0] slot_we;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        run_ff;
  logic [1:0]  slot_ff;
  logic [3:0]  cha_ff;
  logic [3:0]  chb_ff;
  logic        addr_phase;
  logic [7:0]  a_lo;
  logic [31:0] rd_mux;
  logic [15:0] cur_val;
  logic        step;
  logic [1:0]  nxt_slot;
  logic        ctrl_we;

  localparam logic [7:0]  ADDR_13 = {sqs_pkg::IDX_SLOT_13[5:0], 2'b00};
  localparam logic [7:0]  ADDR_14 = {sqs_pkg::IDX_SLOT_14[5:0], 2'b00};
  localparam logic [7:0]  ADDR_15 = {sqs_pkg::IDX_SLOT_15[5:0], 2'b00};
  localparam logic [15:0] RSTS [sqs_pkg::NUM_SLOTS] = '{
    sqs_pkg::RST_SLOT_13, sqs_pkg::RST_SLOT_14, sqs_pkg::RST_SLOT_15};
  localparam logic [5:0]  SELFS [sqs_pkg::NUM_SLOTS] = '{
    sqs_pkg::SELF_13, sqs_pkg::SELF_14, sqs_pkg::SELF_15};
  localparam logic [7:0]  ADDRS [sqs_pkg::NUM_SLOTS] = '{
    ADDR_13, ADDR_14, ADDR_15};

  // Address phase decode; upper address bits must be zero to hit
  assign addr_phase = hsel && hready && htrans[1];
  assign a_lo       = haddr[7:0];

  genvar g;
  generate
    for (g = 0; g < sqs_pkg::NUM_SLOTS; g++) begin : g_slot
      assign slot_we[g] = wr_pend_ff && (wr_addr_ff == ADDRS[g]);
      sqs_slot #(
        .RST_VAL (RSTS[g]),
        .SELF    (SELFS[g])
      ) u_slot (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (slot_we[g]),
        .wdata   (hwdata[15:0]),
        .value   (slot_val[g])
      );
    end
  endgenerate

  assign ctrl_we = wr_pend_ff && (wr_addr_ff == sqs_pkg::ADDR_CTRL);

  // Narrow entries read in the low half, upper bits zero
  assign rd_mux =
    (a_lo == ADDR_13) ? {16'h0000, slot_val[0]} :
    (a_lo == ADDR_14) ? {16'h0000, slot_val[1]} :
    (a_lo == ADDR_15) ? {16'h0000, slot_val[2]} :
    (a_lo == sqs_pkg::ADDR_CTRL) ? {31'h00000000, run_ff} :
    (a_lo == sqs_pkg::ADDR_STATUS) ?
      {22'h000000, slot_ff, chb_ff, cha_ff} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h00000000;
    end else begin
      wr_pend_ff <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_ff <= a_lo;
      if (addr_phase && !hwrite) begin
        hrdata_ff <= (haddr[31:8] == 24'h000000) ? rd_mux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= 1'b0;
    end else if (ctrl_we) begin
      run_ff <= hwdata[sqs_pkg::CTRL_RUN];
    end
  end

  // Stepper: past the last entry here it wraps to the first
  assign cur_val = (slot_ff == 2'h1) ? slot_val[1] :
                   (slot_ff == 2'h2) ? slot_val[2] : slot_val[0];
  assign step    = run_ff && conv_done;
  assign nxt_slot =
    !run_ff ? sqs_pkg::SLOT_FIRST :
    !step ? slot_ff :
    cur_val[sqs_pkg::BIT_RET] ? sqs_pkg::SLOT_FIRST :
    (slot_ff == sqs_pkg::SLOT_LAST) ? sqs_pkg::SLOT_FIRST :
    slot_ff + 2'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_ff <= 2'h0;
      cha_ff  <= 4'h0;
      chb_ff  <= 4'h0;
    end else begin
      slot_ff <= nxt_slot;
      // One edge for both, so the converters never see a mixed pair
      cha_ff  <= cur_val[sqs_pkg::CHA_HI:sqs_pkg::CHA_LO];
      chb_ff  <= cur_val[sqs_pkg::CHB_HI:sqs_pkg::CHB_LO];
    end
  end

  assign hrdata                     = hrdata_ff;
  assign hreadyout                  = 1'b1;
  assign hresp                      = 1'b0;
  assign converter_a_channel_select = cha_ff;
  assign converter_b_channel_select = chb_ff;
  assign active_slot                = slot_ff;
endmodule

//--- sqs_conv_model.sv
// Purpose: converter stand-in giving done pulses
// Assumes: start is one cycle wide
// Notes:   Short fixed latency keeps the run brief
module sqs_conv_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input  logic hclk,
  input  logic hresetn,
  // Control
  input  logic start,
  // Done pulse
  output logic conv_done
);
  int cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= cnt_ff == 1;
      cnt_ff <= start ? LAT : (cnt_ff > 0 ? cnt_ff - 1 : 0);
    end
  end
endmodule

//--- sqs_properties.sv
// Purpose: port checks of the stack bank
// Assumes: hready tied to hreadyout
// Notes:   Run bit is hidden, so a move to slot 0 is legal
module sqs_chk (
  // Clock and reset
  input logic        hclk,
  input logic        hresetn,
  // Bus
  input logic        hsel,
  input logic        hwrite,
  input logic        hready,
  input logic [1:0]  htrans,
  input logic [31:0] haddr,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  // Sequencer
  input logic        conv_done,
  input logic [1:0]  active_slot,
  input logic [3:0]  converter_a_channel_select,
  input logic [3:0]  converter_b_channel_select
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  sequence s_moved; $changed(active_slot); endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("resp");
  a_slot_range: assert property (active_slot != 2'h3)
    else $error("slot 3");
  a_slot_cause: assert property (s_moved |->
    $past(conv_done) || active_slot == 2'h0) else $error("slot moved");
  a_slot_step: assert property (s_moved ##0 active_slot != 2'h0 |->
    active_slot == $past(active_slot) + 2'h1) else $error("slot skip");
  a_rdata_hold: assert property (!rd |=> $stable(hrdata)) else $error("rdata");
  a_miss_zero: assert property (rd && haddr[31:8] != 24'h0 |=>
    hrdata == 32'h0) else $error("miss data");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper");
  a_reset_clear: assert property ($rose(hresetn) |->
    {active_slot, converter_b_channel_select, converter_a_channel_select}
    == 10'h0) else $error("reset state");
endmodule
bind sqs_top sqs_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .conv_done(conv_done), .haddr(haddr), .hrdata(hrdata), .htrans(htrans),
  .active_slot(active_slot),
  .converter_a_channel_select(converter_a_channel_select),
  .converter_b_channel_select(converter_b_channel_select));

//--- sqs_top_tb.sv
// Purpose: bench for the stack bank over AHB-Lite
// Assumes: slave answers within 20 cycles
// Notes:   Codes 1..6 keep A and B apart
module sqs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, start = 0;
  logic        hready, hreadyout, hresp, conv_done;
  logic [1:0]  htrans = 0, slot;
  logic [2:0]  hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [3:0]  cha, chb;
  int          bad_count = 0, n_compared = 0;
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;
  sqs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_done(conv_done), .converter_a_channel_select(cha),
    .converter_b_channel_select(chb), .active_slot(slot));
  sqs_conv_model i_conv (.hclk(hclk), .hresetn(hresetn), .start(start),
    .conv_done(conv_done));
  function automatic logic [31:0] ea(int i);
    return {22'h0, sqs_pkg::IDX_SLOT_13 + 8'(i), 2'h0};
  endfunction
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Selector instead of a reference keeps free simulators happy
  task automatic wt(input bit on_done);
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      if ((on_done ? conv_done : hreadyout) === 1'b1) return;
    end
    bad_count++;
    $display("ERROR %0t wait timed out", $time);
    report_and_stop();
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= sqs_pkg::HTRANS_NONSEQ;
    wt(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(1'b0);
    r = hrdata;
  endtask
  task automatic step(input int s);
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
    wt(1'b1);
    repeat (2) @(posedge hclk);
    chk({30'h0, slot}, 32'(s));
    chk({24'h0, chb, cha}, 32'(34 * s + 33));
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, ea(i), 32'h0);
      chk(r, 32'h5a00 + 32'(i * 512));
    end
    xfer(1'b1, ea(0), 32'h5a33);
    xfer(1'b1, ea(0), 32'hdc33);
    xfer(1'b0, ea(0), 32'h0);
    chk(r, 32'h5a00);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ea(i), 32'hda21 + 32'(i * 546));
      xfer(1'b0, ea(i), 32'h0);
      chk(r, 32'hda21 + 32'(i * 546));
    end
    $display("register tests done");
    xfer(1'b1, 32'h0, 32'h1);
    for (int k = 1; k < 4; k++) step(k % 3);
    xfer(1'b1, ea(1), 32'hdd43);
    step(1);
    step(0);
    step(1);
    // Run off: slot back to the first entry, done pulses ignored
    xfer(1'b1, 32'h0, 32'h0);
    step(0);
    xfer(1'b0, 32'h0, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 32'h4, 32'h0);
    chk(r, 32'h21);
    xfer(1'b0, 32'h100, 32'h0);
    chk(r, 32'h0);
    $display("sequence tests done");
    report_and_stop();
  end
endmodule
